// >>> verilog/wdrt_consts.vh
// Offsets, field positions, reset values and timing values in microseconds of the watchdog block
`ifndef WDRT_CONSTS_VH
`define WDRT_CONSTS_VH
`define WDRT_ADDR_OPTION 12'h000
`define WDRT_ADDR_CTRL 12'h004
`define WDRT_ADDR_STATUS 12'h008
`define WDRT_OPTION_RST 8'hFF
`define WDRT_PSA_BIT 3
`define WDRT_CTRL_CLR_BIT 0
`define WDRT_CTRL_SLEEP_BIT 1
`define WDRT_CTRL_WAKE_BIT 2
`define WDRT_ST_TO_BIT 0
`define WDRT_ST_PD_BIT 1
`define WDRT_ST_RST_BIT 2
`define WDRT_ST_SLEEP_BIT 3
`define WDRT_ST_SRC_LSB 4
`define WDRT_SRC_POR 3'h0
`define WDRT_SRC_MASTER_CLEAR_INPUT 3'h1
`define WDRT_SRC_WDT 3'h2
`define WDRT_SRC_WAKE 3'h3
`define WDRT_LONG_US 18000
`define WDRT_SHORT_US 300
`define WDRT_WDT_US 18000
`define WDRT_CLK_MHZ 20
`define WDRT_OSC_INTERNAL_RC_OSC 3'h0
`define WDRT_OSC_EXTERNAL_RC_OSC 3'h1
`endif

// >>> verilog/wdrt_top.v
// Watchdog timer, scaler shared as watchdog postscaler or timer prescaler, and device reset delay timer with APB registers
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "wdrt_consts.vh"
module wdrt_top #(
    parameter RC_DIV = 20,
    parameter LONG_CYC = (`WDRT_LONG_US * `WDRT_CLK_MHZ + RC_DIV - 1) / RC_DIV,
    parameter SHORT_CYC = (`WDRT_SHORT_US * `WDRT_CLK_MHZ + RC_DIV - 1) / RC_DIV,
    parameter WDT_CYC = (`WDRT_WDT_US * `WDRT_CLK_MHZ) / RC_DIV
)
(
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // Pins and fuses
    input wire por_i,
    input wire master_clear_input_n_i,
    input wire pin_change_i,
    input wire watchdog_enable_fuse_i,
    input wire [2:0] osc_sel_i,
    // Core side
    input wire watchdog_clear_instr_i,
    input wire sleep_instr_i,
    input wire timer_write_i,
    input wire timer_tick_i,
    output reg core_reset_o,
    output reg timer_tick_o,
    output reg [7:0] option_o
);

    localparam S_IDLE = 2'h0;
    localparam S_DELAY = 2'h1;

    // Pin synchronisers
    reg [1:0] por_s_r;
    reg [1:0] master_clear_input_s_r;
    reg [1:0] pin_s_r;
    reg [1:0] fuse_s_r;
    reg [2:0] osc_s1_r;
    reg [2:0] osc_s2_r;
    always @(posedge sys_clk_i)
    begin
        osc_s1_r <= osc_sel_i;
        osc_s2_r <= osc_s1_r;
        por_s_r <= {por_s_r[0], por_i};
        master_clear_input_s_r <= {master_clear_input_s_r[0], master_clear_input_n_i};
        pin_s_r <= {pin_s_r[0], pin_change_i};
        fuse_s_r <= {fuse_s_r[0], watchdog_enable_fuse_i};
    end
    wire por_q = por_s_r[1];
    wire master_clear_input_n_q = master_clear_input_s_r[1];
    wire pin_q = pin_s_r[1];
    wire fuse_q = fuse_s_r[1];

    // Internal RC oscillator tick, free running
    reg [7:0] rc_div_r;
    reg rc_tick_r;
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            rc_div_r <= 8'h00;
            rc_tick_r <= 1'b0;
        end
        else if (rc_div_r == RC_DIV[7:0] - 8'h01)
        begin
            rc_div_r <= 8'h00;
            rc_tick_r <= 1'b1;
        end
        else
        begin
            rc_div_r <= rc_div_r + 8'h01;
            rc_tick_r <= 1'b0;
        end
    end

    // Registers written by software, and the sequencer, counter and scaler state
    reg [7:0] option_r;
    reg sw_clr_r;
    reg sw_sleep_r;
    reg sw_wake_r;
    reg sleeping_r;
    reg to_n_r;
    reg pd_n_r;
    reg [2:0] src_r;
    reg [1:0] state_r;
    reg [19:0] drt_cnt_r;
    reg [19:0] wdt_cnt_r;
    reg [7:0] scaler_r;
    reg wdt_timeout_r;
    reg pin_d_r;

    wire apb_wr = psel_i && penable_i && pwrite_i;
    wire scaler_assign_bit = option_r[`WDRT_PSA_BIT];
    wire [2:0] ratio = option_r[2:0];
    wire do_clear = watchdog_clear_instr_i || sw_clr_r;
    wire do_sleep = sleep_instr_i || sw_sleep_r;
    wire pin_rise = pin_q && !pin_d_r;
    wire wake_evt = sleeping_r && (pin_rise || sw_wake_r);
    wire master_clear_input_evt = !master_clear_input_n_q;
    // Every reset kind restores option; power-on clears the scaler, other kinds clear it unless a timer tick lands with scaler_assign_bit clear
    wire any_rst_evt = por_q || master_clear_input_evt || wdt_timeout_r || wake_evt;

    function [19:0] drt_len;
        input [2:0] src;
        input [2:0] osc;
        begin
            if (src == `WDRT_SRC_POR)
                drt_len = LONG_CYC[19:0];
            else if (osc == `WDRT_OSC_INTERNAL_RC_OSC || osc == `WDRT_OSC_EXTERNAL_RC_OSC)
                drt_len = SHORT_CYC[19:0];
            else
                drt_len = LONG_CYC[19:0];
        end
    endfunction

    // Scaler tap for ratio code n: low n bits all zero marks divide by 2^n
    function tap;
        input [7:0] cnt;
        input [2:0] n;
        begin
            tap = (n == 3'h0) ? 1'b1 : ((cnt & ((8'h01 << n) - 8'h01)) == 8'h00);
        end
    endfunction

    // Reset sequencer and delay timer
    always @(posedge sys_clk_i)
    begin
        pin_d_r <= pin_q;
        if (!rst_n_i || por_q)
        begin
            state_r <= S_DELAY;
            src_r <= `WDRT_SRC_POR;
            drt_cnt_r <= LONG_CYC[19:0];
            core_reset_o <= 1'b1;
            to_n_r <= 1'b1;
            pd_n_r <= 1'b1;
            sleeping_r <= 1'b0;
        end
        else if (master_clear_input_evt || wdt_timeout_r || wake_evt)
        begin
            state_r <= S_DELAY;
            src_r <= master_clear_input_evt ? `WDRT_SRC_MASTER_CLEAR_INPUT :
                     wdt_timeout_r ? `WDRT_SRC_WDT : `WDRT_SRC_WAKE;
            drt_cnt_r <= drt_len(master_clear_input_evt ? `WDRT_SRC_MASTER_CLEAR_INPUT : `WDRT_SRC_WDT, osc_s2_r);
            core_reset_o <= 1'b1;
            if (wdt_timeout_r)
                to_n_r <= 1'b0;
            if (!master_clear_input_evt)
                sleeping_r <= 1'b0;
        end
        else
        begin
            if (do_clear)
            begin
                to_n_r <= 1'b1;
                pd_n_r <= 1'b1;
            end
            if (do_sleep && !core_reset_o)
            begin
                to_n_r <= 1'b1;
                pd_n_r <= 1'b0;
                sleeping_r <= 1'b1;
            end
            case (state_r)
                S_DELAY:
                begin
                    if (rc_tick_r)
                    begin
                        if (drt_cnt_r <= 20'h00001)
                        begin
                            state_r <= S_IDLE;
                            core_reset_o <= 1'b0;
                        end
                        drt_cnt_r <= drt_cnt_r - 20'h00001;
                    end
                end
                S_IDLE:
                    core_reset_o <= 1'b0;
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

    // Watchdog counter and shared scaler
    always @(posedge sys_clk_i)
    begin
        wdt_timeout_r <= 1'b0;
        if (!rst_n_i || any_rst_evt)
        begin
            wdt_cnt_r <= 20'h00000;
            scaler_r <= 8'h00;
        end
        else if (!fuse_q)
        begin
            wdt_cnt_r <= 20'h00000;
            scaler_r <= scaler_assign_bit ? 8'h00 : scaler_r;
        end
        else if (do_clear || do_sleep)
        begin
            wdt_cnt_r <= 20'h00000;
            if (scaler_assign_bit)
                scaler_r <= 8'h00;
        end
        else if (rc_tick_r)
        begin
            if (wdt_cnt_r >= WDT_CYC[19:0] - 20'h00001)
            begin
                wdt_cnt_r <= 20'h00000;
                if (!scaler_assign_bit)
                    wdt_timeout_r <= 1'b1;
                else
                begin
                    scaler_r <= scaler_r + 8'h01;
                    if (tap(scaler_r + 8'h01, ratio))
                        wdt_timeout_r <= 1'b1;
                end
            end
            else
                wdt_cnt_r <= wdt_cnt_r + 20'h00001;
        end
        if (rst_n_i && !por_q && fuse_q && !scaler_assign_bit && timer_write_i)
            scaler_r <= 8'h00;
        else if (rst_n_i && !por_q && !scaler_assign_bit && timer_tick_i)
            scaler_r <= scaler_r + 8'h01;
    end

    // Timer side of the scaler
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            timer_tick_o <= 1'b0;
        else if (scaler_assign_bit)
            timer_tick_o <= timer_tick_i;
        else
            timer_tick_o <= timer_tick_i && tap(scaler_r + 8'h01, ratio + 3'h1);
    end

    // APB slave, one wait-free access phase
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            option_r <= `WDRT_OPTION_RST;
            option_o <= `WDRT_OPTION_RST;
            sw_clr_r <= 1'b0;
            sw_sleep_r <= 1'b0;
            sw_wake_r <= 1'b0;
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            sw_clr_r <= 1'b0;
            sw_sleep_r <= 1'b0;
            sw_wake_r <= 1'b0;
            if (any_rst_evt)
                option_r <= `WDRT_OPTION_RST;
            option_o <= option_r;
            pready_o <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
            if (psel_i && !penable_i)
            begin
                case (paddr_i)
                    `WDRT_ADDR_OPTION: prdata_o <= 32'h00000000;
                    `WDRT_ADDR_CTRL: prdata_o <= 32'h00000000;
                    `WDRT_ADDR_STATUS:
                        prdata_o <= {24'h000000, 1'b0, src_r, sleeping_r,
                                     core_reset_o, pd_n_r, to_n_r};
                    default: pslverr_o <= 1'b1;
                endcase
            end
            if (apb_wr && pready_o)
            begin
                if (paddr_i == `WDRT_ADDR_OPTION)
                    option_r <= pwdata_i[7:0];
                if (paddr_i == `WDRT_ADDR_CTRL)
                begin
                    sw_clr_r <= pwdata_i[`WDRT_CTRL_CLR_BIT];
                    sw_sleep_r <= pwdata_i[`WDRT_CTRL_SLEEP_BIT];
                    sw_wake_r <= pwdata_i[`WDRT_CTRL_WAKE_BIT];
                end
            end
        end
    end

endmodule

// >>> tb/wdrt_sva.sv
// Port assertions for the watchdog and reset delay block
`timescale 1ns/10ps
module wdrt_sva (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // APB
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    // Pins and core side
    input wire master_clear_input_n_i,
    input wire timer_tick_i,
    input wire core_reset_o,
    input wire timer_tick_o,
    input wire [7:0] option_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_rd_opt;
        psel_i && penable_i && pready_o && !pwrite_i && paddr_i == 12'h000;
    endsequence
    property p_ready;
        s_setup |=> pready_o;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_ready_acc;
        pready_o |-> psel_i && penable_i;
    endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
    property p_err;
        pslverr_o |-> pready_o;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rd_opt;
        s_rd_opt |-> prdata_o == 32'h00000000;
    endproperty
    a_rd_opt: assert property (p_rd_opt) else $error("option read not zero");
    property p_hold;
        $rose(rst_n_i) |-> core_reset_o [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("core left reset early");
    property p_master_clear_input;
        $fell(master_clear_input_n_i) |-> ##[1:4] core_reset_o;
    endproperty
    a_master_clear_input: assert property (p_master_clear_input) else $error("clear pin ignored");
    property p_master_clear_input_hold;
        !master_clear_input_n_i && core_reset_o |=> core_reset_o;
    endproperty
    a_master_clear_input_hold: assert property (p_master_clear_input_hold) else $error("released under clear");
    property p_tick;
        timer_tick_i ##1 option_o[3] |-> timer_tick_o;
    endproperty
    a_tick: assert property (p_tick) else $error("timer tick scaled");
endmodule
bind wdrt_top wdrt_sva u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .timer_tick_i(timer_tick_i),
    .master_clear_input_n_i(master_clear_input_n_i), .core_reset_o(core_reset_o),
    .timer_tick_o(timer_tick_o), .option_o(option_o));

// >>> tb/wdrt_core_model.sv
// Processor core model issuing clear and sleep instructions
`timescale 1ns/10ps
module wdrt_core_model (
    // Clock and requests
    input wire logic sys_clk_i,
    input wire logic core_reset_i,
    input wire logic clr_req_i,
    input wire logic slp_req_i,
    // Instructions
    output logic watchdog_clear_instr_o = 1'b0,
    output logic sleep_instr_o = 1'b0
);
    // A core in reset executes nothing
    always @(posedge sys_clk_i)
    begin
        watchdog_clear_instr_o <= clr_req_i && !core_reset_i;
        sleep_instr_o <= slp_req_i && !core_reset_i;
    end
endmodule

// >>> tb/wdrt_top_tb.sv
// Self-checking bench for the watchdog and reset delay block
`timescale 1ns/10ps
module wdrt_top_tb;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, por = 1'b0;
    logic master_clear_input_n = 1'b1, pin = 1'b0, fuse = 1'b1, clr_req = 1'b0, slp_req = 1'b0, tick = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] osc = 3'h0;
    logic pready, perr, crst, tick_o, wclr, wslp, er;
    logic [7:0] opt;
    logic [45:0] rows [5] = '{{1'b1, 12'h000, 32'h5A, 1'b0}, {1'b0, 12'h000, 32'h0, 1'b0},
        {1'b0, 12'h00C, 32'h0, 1'b1}, {1'b1, 12'h010, 32'hFF, 1'b1}, {1'b0, 12'h004, 32'h0, 1'b0}};
    integer mismatches = 0, tests_run = 0, cyc = 0, n, r, b, k;
    always #25 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    wdrt_top #(.RC_DIV(2), .LONG_CYC(40), .SHORT_CYC(10), .WDT_CYC(30)) dut (.sys_clk_i(clk),
        .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .por_i(por),
        .master_clear_input_n_i(master_clear_input_n), .pin_change_i(pin), .watchdog_enable_fuse_i(fuse),
        .osc_sel_i(osc), .watchdog_clear_instr_i(wclr), .sleep_instr_i(wslp),
        .timer_write_i(1'b0), .timer_tick_i(tick), .core_reset_o(crst),
        .timer_tick_o(tick_o), .option_o(opt));
    wdrt_core_model core (.sys_clk_i(clk), .core_reset_i(crst), .clr_req_i(clr_req),
        .slp_req_i(slp_req), .watchdog_clear_instr_o(wclr), .sleep_instr_o(wslp));
    task stop_test;
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task rng(input string nm, input integer v, input integer lo, input integer hi);
        chk(nm, v, (v < lo) ? lo : ((v > hi) ? hi : v));
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = perr;
        psel <= 1'b0; pen <= 1'b0;
        @(posedge clk);
    endtask
    task ins(input logic s);
        if (s) slp_req <= 1'b1;
        else clr_req <= 1'b1;
        @(posedge clk);
        slp_req <= 1'b0; clr_req <= 1'b0;
        @(posedge clk);
    endtask
    task wt(input logic v, input integer mx);
        n = 0;
        while (crst !== v && n < mx) begin @(posedge clk); n++; end
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            mismatches++;
            stop_test;
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("opt_rst", opt, 8'hFF);
        wt(0, 200); rng("por_dly", n, 78, 95);
        for (k = 0; k < 5; k++)
        begin
            apb(rows[k][45], rows[k][44:33], rows[k][32:1]);
            chk("perr", er, rows[k][0]);
            chk("rdata", rd, 32'h0);
        end
        chk("opt", opt, 8'h5A);
        apb(1'b1, 12'h000, 32'h0);
        repeat (6) begin ins(1'b0); repeat (40) @(posedge clk); end
        chk("no_to", crst, 1'b0);
        ins(1'b1);
        wt(1, 200); rng("wdt_to", n, 56, 72);
        wt(0, 100); rng("wdt_dly", n, 18, 32);
        apb(1'b0, 12'h008, 32'h0);
        chk("st_wdt", rd & 32'h75, 32'h20);
        chk("opt_wdt", opt, 8'hFF);
        for (k = 0; k < 3; k++)
        begin
            r = (k == 2) ? 7 : k;
            apb(1'b1, 12'h000, 32'h8 | r);
            ins(1'b1);
            wt(1, 9000); rng("ratio", n, (60 << r) - 4, (60 << r) + 16);
            wt(0, 100);
        end
        fuse <= 1'b0;
        apb(1'b1, 12'h000, 32'h0);
        b = 0;
        repeat (40) begin @(posedge clk); b += tick_o; end
        rng("tdiv", b, 9, 11);
        ins(1'b1);
        wt(1, 300); rng("fuse", n, 300, 300);
        pin <= 1'b1;
        wt(1, 20); rng("wake", n, 1, 10);
        wt(0, 100);
        apb(1'b0, 12'h008, 32'h0);
        chk("st_wake", rd & 32'h70, 32'h30);
        pin <= 1'b0; fuse <= 1'b1;
        for (k = 0; k < 3; k++)
        begin
            osc <= (k == 1) ? 3'h2 : 3'h0;
            b = (k == 0) ? 20 : 80;
            @(posedge clk);
            if (k == 2) por <= 1'b1;
            else master_clear_input_n <= 1'b0;
            repeat (6) @(posedge clk);
            chk("in_rst", crst, 1'b1);
            por <= 1'b0; master_clear_input_n <= 1'b1;
            wt(0, 200); rng("rst_dly", n, b - 2, b + 14);
            apb(1'b0, 12'h008, 32'h0);
            chk("st_src", rd & 32'h70, (k == 2) ? 32'h0 : 32'h10);
        end
        stop_test;
    end
endmodule
